// [rtl/trig_route_map.svh]
// offsets, field positions and reset values of the trigger routing block
// assumes byte addressing on a 32-bit register bus, one register per word
`ifndef TRIG_ROUTE_MAP_SVH
`define TRIG_ROUTE_MAP_SVH

`define TR_ADDR_W 4
`define TR_DATA_W 32
`define TR_BE_W 4

// register byte offsets
`define TR_OFF_CTRL 4'h0
`define TR_OFF_A_CFG 4'h4
`define TR_OFF_B_CFG 4'h8
`define TR_OFF_LEVELS 4'hc

// control register bit positions
`define TR_CTRL_A2_DRIVE 0
`define TR_CTRL_A2_RECEIVE 1
`define TR_CTRL_A4_DRIVE 2
`define TR_CTRL_A4_RECEIVE 3
`define TR_CTRL_W 4

// pin field layout, one 4-bit field per pin, pin n at bits 4n+3..4n
`define TR_PIN_COUNT 7
`define TR_FIELD_W 4
`define TR_CFG_W 28
`define TR_FIELD_SRC_LSB 0
`define TR_FIELD_EN_BIT 3

// levels register layout
`define TR_LVL_A_LSB 0
`define TR_LVL_B_LSB 8

// reset values
`define TR_CTRL_RST 4'h0
`define TR_CFG_RST 28'h0000000
`define TR_IDLE_LEVEL 1'b1

`endif

// [rtl/trig_route_pkg.sv]
// types shared by the trigger crossbar routing block
// assumes trig_route_map.svh is on the include path
package trig_route_pkg;
    `include "trig_route_map.svh"

    typedef struct packed {
        logic a4_receive;
        logic a4_drive;
        logic a2_receive;
        logic a2_drive;
    } route_ctrl_t;

    typedef struct packed {
        logic pin_drive_enable;
        logic [2:0] source_pin;
    } pin_field_t;

    typedef pin_field_t [`TR_PIN_COUNT-1:0] pin_fields_t;

    typedef struct packed {
        logic waitrequest;
        logic [`TR_DATA_W-1:0] readdata;
    } bus_resp_t;

    typedef struct packed {
        logic [`TR_PIN_COUNT-1:0] out;
        logic [`TR_PIN_COUNT-1:0] oe;
    } trig_drive_t;

    typedef struct packed {
        logic convert_out;
        logic convert_oe;
        logic counter5_source_input_out;
        logic counter5_source_input_oe;
        logic ext_trig_out;
        logic ext_trig_oe;
        logic frequency;
        logic counter2;
        logic counter5;
        logic counter1;
    } connector_drive_t;

    typedef struct packed {
        logic external_convert_n;
        logic counter1_gate_input;
        logic counter5_source_input;
        logic timer_trigger_n;
        logic external_trigger_n;
    } board_rx_t;

    typedef struct packed {
        route_ctrl_t ctrl;
        pin_fields_t a_cfg;
        pin_fields_t b_cfg;
        bus_resp_t bus;
        trig_drive_t trig;
        connector_drive_t conn;
        board_rx_t rx;
        logic [`TR_PIN_COUNT-1:0] a_level;
    } route_state_t;

    // source selects 0..6 name a pin; 7 names nothing and reads low
    function automatic logic pick_pin(input logic [`TR_PIN_COUNT-1:0] levels, input logic [2:0] sel);
        logic v;
        v = 1'b0;
        if (sel < 3'h7) begin
            v = levels[sel];
        end
        return v;
    endfunction
endpackage

// [rtl/trigger_crossbar.sv]
// 7x7 crossbar between the board-side A pins and the trigger bus B pins
// purely combinational; the instantiating module registers every result
`timescale 1ns/1ps
`include "trig_route_map.svh"
module trigger_crossbar
    import trig_route_pkg::*;
(
    // configuration
    input wire pin_fields_t a_cfg,
    input wire pin_fields_t b_cfg,
    // levels presented by the board on each A pin when the crossbar leaves it
    input wire logic [`TR_PIN_COUNT-1:0] a_board,
    // resolved trigger line levels
    input wire logic [`TR_PIN_COUNT-1:0] trig_in,
    // results
    output logic [`TR_PIN_COUNT-1:0] a_level,
    output trig_drive_t trig
);
    always_comb begin
        for (int i = 0; i < `TR_PIN_COUNT; i++) begin
            // an A pin with its enable clear is left to the board
            if (a_cfg[i].pin_drive_enable) begin
                a_level[i] = pick_pin(trig_in, a_cfg[i].source_pin);
            end else begin
                a_level[i] = a_board[i];
            end
        end
        for (int j = 0; j < `TR_PIN_COUNT; j++) begin
            trig.oe[j] = b_cfg[j].pin_drive_enable;
            trig.out[j] = b_cfg[j].pin_drive_enable & pick_pin(a_level, b_cfg[j].source_pin);
        end
    end
endmodule

// [rtl/trigger_pin_router.sv]
// trigger crossbar pin routing: board timing signals onto the crossbar A side,
// trigger bus lines on the B side, with shared-pin control and an Avalon-MM slave
// assumes all pin inputs are synchronous to core_clk and the pin wires are
// resolved outside from each out/oe pair
//
// Summary of operation
// - seven A pins carry board timing signals
// - seven B pins, one per trigger line
// - fixed signal assignment to each A pin
// - nine signals share seven A pins
// - all nine signals also on front connector
// - drive bit puts counter 2 output on A2
// - receive bit feeds counter 1 gate from A2
// - both A2 bits loop counter2 into gate; here only while the A2 enable is clear
// - drive bit puts counter 5 output on A4
// - receive bit sources timer trigger from A4
// - both A4 bits loop counter5 into trigger; here only while the A4 enable is clear
// - receive clear uses external timer trigger input
// - pin with enable clear is never driven
//
// The Avalon-MM register port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "trig_route_map.svh"
module trigger_pin_router
    import trig_route_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // avalon-mm slave
    input wire logic [`TR_ADDR_W-1:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [`TR_DATA_W-1:0] writedata,
    input wire logic [`TR_BE_W-1:0] byteenable,
    output logic [`TR_DATA_W-1:0] readdata,
    output logic waitrequest,
    // board-side signals produced by the counters
    input wire logic frequency_output,
    input wire logic counter2_output,
    input wire logic counter5_output,
    input wire logic counter1_output,
    // board-side signals delivered to the counters and converter
    output logic external_convert_n,
    output logic counter1_gate_input,
    output logic counter5_source_input,
    output logic timer_trigger_n,
    output logic external_trigger_n,
    // front connector, two-way pins
    input wire logic conn_convert_n_in,
    output logic conn_convert_n_out,
    output logic conn_convert_n_oe,
    input wire logic conn_counter5_source_input_in,
    output logic conn_counter5_source_input_out,
    output logic conn_counter5_source_input_oe,
    input wire logic conn_ext_trigger_n_in,
    output logic conn_ext_trigger_n_out,
    output logic conn_ext_trigger_n_oe,
    // front connector, one-way pins
    input wire logic conn_counter1_gate_input_in,
    input wire logic external_timer_trigger_n,
    output logic conn_frequency_output,
    output logic conn_counter2_output,
    output logic conn_counter5_output,
    output logic conn_counter1_output,
    // trigger bus lines 0..6
    input wire logic [`TR_PIN_COUNT-1:0] trigger_line_in,
    output logic [`TR_PIN_COUNT-1:0] trigger_line_out,
    output logic [`TR_PIN_COUNT-1:0] trigger_line_oe
);
    route_state_t state_r;
    route_state_t state_nxt;
    logic [`TR_PIN_COUNT-1:0] a_board;
    logic [`TR_PIN_COUNT-1:0] a_level;
    trig_drive_t trig_drive;
    logic req;
    logic take;

    // byte-lane merge used by every writable register
    function automatic logic [`TR_DATA_W-1:0] merge_bytes(
        input logic [`TR_DATA_W-1:0] old,
        input logic [`TR_DATA_W-1:0] wdata,
        input logic [`TR_BE_W-1:0] be
    );
        logic [`TR_DATA_W-1:0] v;
        v = old;
        for (int b = 0; b < `TR_BE_W; b++) begin
            if (be[b]) begin
                v[b*8 +: 8] = wdata[b*8 +: 8];
            end
        end
        return v;
    endfunction

    // what the board presents on each A pin when the crossbar does not drive it;
    // a shared pin whose drive bit is clear idles high, like a pulled-up line
    always_comb begin
        a_board[0] = conn_convert_n_in;
        a_board[1] = frequency_output;
        if (state_r.ctrl.a2_drive) begin
            a_board[2] = counter2_output;
        end else begin
            a_board[2] = `TR_IDLE_LEVEL;
        end
        a_board[3] = conn_counter5_source_input_in;
        if (state_r.ctrl.a4_drive) begin
            a_board[4] = counter5_output;
        end else begin
            a_board[4] = `TR_IDLE_LEVEL;
        end
        a_board[5] = counter1_output;
        a_board[6] = conn_ext_trigger_n_in;
    end

    trigger_crossbar u_xbar (
        .a_cfg(state_r.a_cfg),
        .b_cfg(state_r.b_cfg),
        .a_board(a_board),
        .trig_in(trigger_line_in),
        .a_level(a_level),
        .trig(trig_drive)
    );

    // a request is answered one cycle after it is seen, waitrequest low for one cycle
    assign req = read | write;
    assign take = req & ~state_r.bus.waitrequest;

    always_comb begin
        logic [`TR_DATA_W-1:0] merged;
        merged = '0;
        state_nxt = state_r;

        // bus handshake
        state_nxt.bus.waitrequest = ~(req & state_r.bus.waitrequest);
        if (req & state_r.bus.waitrequest & read) begin
            case (address)
                `TR_OFF_CTRL: begin
                    state_nxt.bus.readdata = {{(`TR_DATA_W-`TR_CTRL_W){1'b0}}, state_r.ctrl};
                end
                `TR_OFF_A_CFG: begin
                    state_nxt.bus.readdata = {{(`TR_DATA_W-`TR_CFG_W){1'b0}}, state_r.a_cfg};
                end
                `TR_OFF_B_CFG: begin
                    state_nxt.bus.readdata = {{(`TR_DATA_W-`TR_CFG_W){1'b0}}, state_r.b_cfg};
                end
                `TR_OFF_LEVELS: begin
                    state_nxt.bus.readdata = '0;
                    state_nxt.bus.readdata[`TR_LVL_A_LSB +: `TR_PIN_COUNT] = state_r.a_level;
                    state_nxt.bus.readdata[`TR_LVL_B_LSB +: `TR_PIN_COUNT] = trigger_line_in;
                end
                default: begin
                    state_nxt.bus.readdata = '0;
                end
            endcase
        end

        // writes land at the edge where waitrequest is seen low
        if (take & write) begin
            case (address)
                `TR_OFF_CTRL: begin
                    merged = merge_bytes({{(`TR_DATA_W-`TR_CTRL_W){1'b0}}, state_r.ctrl},
                        writedata, byteenable);
                    // bits above the field are not stored, so they read back zero
                    state_nxt.ctrl = route_ctrl_t'(merged[`TR_CTRL_W-1:0]);
                end
                `TR_OFF_A_CFG: begin
                    merged = merge_bytes({{(`TR_DATA_W-`TR_CFG_W){1'b0}}, state_r.a_cfg},
                        writedata, byteenable);
                    state_nxt.a_cfg = pin_fields_t'(merged[`TR_CFG_W-1:0]);
                end
                `TR_OFF_B_CFG: begin
                    merged = merge_bytes({{(`TR_DATA_W-`TR_CFG_W){1'b0}}, state_r.b_cfg},
                        writedata, byteenable);
                    state_nxt.b_cfg = pin_fields_t'(merged[`TR_CFG_W-1:0]);
                end
                default: begin
                    // levels register and unmapped offsets ignore writes
                    state_nxt.ctrl = state_r.ctrl;
                end
            endcase
        end

        // A-pin levels for readback only; the B side takes them straight from the crossbar
        state_nxt.a_level = a_level;

        // trigger bus drive; a B pin with its enable clear floats
        state_nxt.trig = trig_drive;

        // board receivers
        state_nxt.rx.external_convert_n = a_level[0];
        state_nxt.rx.counter5_source_input = a_level[3];
        state_nxt.rx.external_trigger_n = a_level[6];
        // with both A2 bits set and the A2 enable clear the gate sees counter 2 through the pin
        if (state_r.ctrl.a2_receive) begin
            state_nxt.rx.counter1_gate_input = a_level[2];
        end else begin
            state_nxt.rx.counter1_gate_input = conn_counter1_gate_input_in;
        end
        // with both A4 bits set and the A4 enable clear the trigger sees counter 5 through the pin
        if (state_r.ctrl.a4_receive) begin
            state_nxt.rx.timer_trigger_n = a_level[4];
        end else begin
            state_nxt.rx.timer_trigger_n = external_timer_trigger_n;
        end

        // front connector: two-way pins driven only while the crossbar drives
        // their A pin, otherwise they stay inputs
        state_nxt.conn.convert_out = a_level[0];
        state_nxt.conn.convert_oe = state_r.a_cfg[0].pin_drive_enable;
        state_nxt.conn.counter5_source_input_out = a_level[3];
        state_nxt.conn.counter5_source_input_oe = state_r.a_cfg[3].pin_drive_enable;
        state_nxt.conn.ext_trig_out = a_level[6];
        state_nxt.conn.ext_trig_oe = state_r.a_cfg[6].pin_drive_enable;
        state_nxt.conn.frequency = frequency_output;
        state_nxt.conn.counter2 = counter2_output;
        state_nxt.conn.counter5 = counter5_output;
        state_nxt.conn.counter1 = counter1_output;
    end

    // reset leaves every trigger line and two-way connector pin undriven and both shared pins released
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            state_r.ctrl <= `TR_CTRL_RST;
            state_r.a_cfg <= `TR_CFG_RST;
            state_r.b_cfg <= `TR_CFG_RST;
            state_r.bus.waitrequest <= 1'b1;
            state_r.bus.readdata <= 32'h00000000;
            state_r.trig <= '0;
            state_r.conn <= '0;
            state_r.rx <= '1;
            state_r.a_level <= '1;
        end else begin
            state_r <= state_nxt;
        end
    end

    // outputs straight from the state register
    assign readdata = state_r.bus.readdata;
    assign waitrequest = state_r.bus.waitrequest;
    assign external_convert_n = state_r.rx.external_convert_n;
    assign counter1_gate_input = state_r.rx.counter1_gate_input;
    assign counter5_source_input = state_r.rx.counter5_source_input;
    assign timer_trigger_n = state_r.rx.timer_trigger_n;
    assign external_trigger_n = state_r.rx.external_trigger_n;
    assign conn_convert_n_out = state_r.conn.convert_out;
    assign conn_convert_n_oe = state_r.conn.convert_oe;
    assign conn_counter5_source_input_out = state_r.conn.counter5_source_input_out;
    assign conn_counter5_source_input_oe = state_r.conn.counter5_source_input_oe;
    assign conn_ext_trigger_n_out = state_r.conn.ext_trig_out;
    assign conn_ext_trigger_n_oe = state_r.conn.ext_trig_oe;
    assign conn_frequency_output = state_r.conn.frequency;
    assign conn_counter2_output = state_r.conn.counter2;
    assign conn_counter5_output = state_r.conn.counter5;
    assign conn_counter1_output = state_r.conn.counter1;
    assign trigger_line_out = state_r.trig.out;
    assign trigger_line_oe = state_r.trig.oe;
endmodule

// [test/trigger_pin_router_props.sv]
// concurrent checks on the trigger pin router, seeing only its ports
// assumes a bench drives the bus one request at a time; config is shadowed here from bus writes
`timescale 1ns/1ps
module trigger_pin_router_props (
    // clock, reset and bus
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    // board side
    input wire logic frequency_output,
    input wire logic counter2_output,
    input wire logic counter5_output,
    input wire logic counter1_output,
    input wire logic counter1_gate_input,
    input wire logic timer_trigger_n,
    input wire logic conn_counter1_gate_input_in,
    input wire logic external_timer_trigger_n,
    input wire logic conn_frequency_output,
    input wire logic conn_counter2_output,
    input wire logic conn_counter5_output,
    input wire logic conn_counter1_output,
    // trigger lines
    input wire logic [6:0] trigger_line_out,
    input wire logic [6:0] trigger_line_oe
);
    logic run_r;
    logic run2_r;
    logic [3:0] ctrl_r;
    logic [27:0] acfg_r;
    logic [27:0] bcfg_r;
    logic [31:0] cur;
    logic [31:0] wr_nxt;
    wire a2_loop = ctrl_r[1:0] == 2'h3 && !acfg_r[11];
    wire a4_loop = ctrl_r[3:2] == 2'h3 && !acfg_r[19];
    wire [6:0] b_en = {bcfg_r[27], bcfg_r[23], bcfg_r[19], bcfg_r[15], bcfg_r[11], bcfg_r[7], bcfg_r[3]};
    wire [3:0] brd = {frequency_output, counter2_output, counter5_output, counter1_output};
    assign cur = address == 4'h0 ? {28'h0, ctrl_r} : address == 4'h4 ? {4'h0, acfg_r} : {4'h0, bcfg_r};
    always_comb begin
        wr_nxt = cur;
        for (int i = 0; i < 4; i++) begin
            if (byteenable[i]) begin
                wr_nxt[8*i+:8] = writedata[8*i+:8];
            end
        end
    end
    // shadow updates at the edge where the design takes the write
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            run_r <= 1'h0;
            run2_r <= 1'h0;
            ctrl_r <= 4'h0;
            acfg_r <= 28'h0;
            bcfg_r <= 28'h0;
        end else begin
            run_r <= 1'h1;
            run2_r <= run_r;
            if (write && !waitrequest && address == 4'h0) ctrl_r <= wr_nxt[3:0];
            if (write && !waitrequest && address == 4'h4) acfg_r <= wr_nxt[27:0];
            if (write && !waitrequest && address == 4'h8) bcfg_r <= wr_nxt[27:0];
        end
    end
    // the first edge after release still sees reset-time samples; disable iff reads
    // current values, so a second stage is needed to skip that edge
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst || !run2_r);
    sequence s_ack;
        !waitrequest ##1 waitrequest;
    endsequence
    property p_ack;
        (read || write) && waitrequest |=> s_ack;
    endproperty
    a_ack: assert property (p_ack) else $error("bus answer not a single cycle");
    property p_rd;
        read && !waitrequest && address[1:0] == 2'h0 && address != 4'hc |-> readdata == cur;
    endproperty
    a_rd: assert property (p_rd) else $error("register read back wrong");
    property p_unm;
        read && !waitrequest && address[1:0] != 2'h0 |-> readdata == 32'h0;
    endproperty
    a_unm: assert property (p_unm) else $error("unmapped read not zero");
    property p_gate_ext;
        !$past(ctrl_r[1]) |-> counter1_gate_input == $past(conn_counter1_gate_input_in);
    endproperty
    a_gate_ext: assert property (p_gate_ext) else $error("gate taken from shared pin");
    property p_gate_loop;
        $past(a2_loop) |-> counter1_gate_input == $past(counter2_output);
    endproperty
    a_gate_loop: assert property (p_gate_loop) else $error("gate not fed by counter 2");
    property p_tmr_ext;
        !$past(ctrl_r[3]) |-> timer_trigger_n == $past(external_timer_trigger_n);
    endproperty
    a_tmr_ext: assert property (p_tmr_ext) else $error("timer trigger not from connector");
    property p_tmr_loop;
        $past(a4_loop) |-> timer_trigger_n == $past(counter5_output);
    endproperty
    a_tmr_loop: assert property (p_tmr_loop) else $error("timer trigger not fed by counter 5");
    property p_oe;
        trigger_line_oe == $past(b_en) && (trigger_line_out & ~trigger_line_oe) == 7'h0;
    endproperty
    a_oe: assert property (p_oe) else $error("trigger line driven while disabled");
    property p_conn;
        {conn_frequency_output, conn_counter2_output, conn_counter5_output, conn_counter1_output} == $past(brd);
    endproperty
    a_conn: assert property (p_conn) else $error("connector copy wrong");
    property p_rst;
        disable iff (1'h0) rst |-> waitrequest && trigger_line_oe == 7'h0;
    endproperty
    a_rst: assert property (p_rst) else $error("outputs active in reset");
endmodule

// [test/trig_bus_peer.sv]
// other boards on the seven shared trigger lines, resolving each wire
// assumes the bench chooses what the other boards drive
`timescale 1ns/1ps
module trig_bus_peer (
    // our board
    input wire logic [6:0] dut_out,
    input wire logic [6:0] dut_oe,
    // other boards
    input wire logic [6:0] peer_val,
    input wire logic [6:0] peer_oe,
    // resolved lines
    output logic [6:0] line
);
    // released lines are pulled high; two drivers at once give an unknown level
    always_comb begin
        for (int n = 0; n < 7; n++) begin
            line[n] = dut_oe[n] ? dut_out[n] : (peer_oe[n] ? peer_val[n] : 1'h1);
            if (dut_oe[n] && peer_oe[n]) line[n] = 1'hx;
        end
    end
endmodule

// [test/trigger_pin_router_bench.sv]
// self-checking bench for the trigger pin router over its Avalon-MM slave
// assumes the peer model resolves the trigger lines; connector pins are pulled high
`timescale 1ns/1ps
module trigger_pin_router_bench;
    logic core_clk = 0, rst = 0, read = 0, write = 0, waitrequest;
    logic [3:0] address = 4'h0, byteenable = 4'hf;
    logic [31:0] writedata = 32'h0, readdata, q;
    logic frequency_output = 0, counter2_output = 0, counter5_output = 0, counter1_output = 0;
    logic external_convert_n, counter1_gate_input, counter5_source_input, timer_trigger_n, external_trigger_n;
    logic conn_convert_n_in, conn_convert_n_out, conn_convert_n_oe, conn_counter5_source_input_in, conn_counter5_source_input_out;
    logic conn_counter5_source_input_oe, conn_ext_trigger_n_in, conn_ext_trigger_n_out, conn_ext_trigger_n_oe;
    logic conn_counter1_gate_input_in = 0, external_timer_trigger_n = 1;
    logic conn_frequency_output, conn_counter2_output, conn_counter5_output, conn_counter1_output;
    logic [6:0] trigger_line_in, trigger_line_out, trigger_line_oe, peer_val = 7'h0, peer_oe = 7'h0;
    int n_mismatch = 0, num_checks = 0, cycles = 0;
    assign conn_convert_n_in = conn_convert_n_oe ? conn_convert_n_out : 1'h1;
    assign conn_counter5_source_input_in = conn_counter5_source_input_oe ? conn_counter5_source_input_out : 1'h1;
    assign conn_ext_trigger_n_in = conn_ext_trigger_n_oe ? conn_ext_trigger_n_out : 1'h1;
    trigger_pin_router dut (.core_clk, .rst, .address, .read, .write, .writedata, .byteenable, .readdata,
        .waitrequest, .frequency_output, .counter2_output, .counter5_output, .counter1_output,
        .external_convert_n, .counter1_gate_input, .counter5_source_input, .timer_trigger_n, .external_trigger_n,
        .conn_convert_n_in, .conn_convert_n_out, .conn_convert_n_oe, .conn_counter5_source_input_in, .conn_counter5_source_input_out,
        .conn_counter5_source_input_oe, .conn_ext_trigger_n_in, .conn_ext_trigger_n_out, .conn_ext_trigger_n_oe,
        .conn_counter1_gate_input_in, .external_timer_trigger_n, .conn_frequency_output, .conn_counter2_output,
        .conn_counter5_output, .conn_counter1_output, .trigger_line_in, .trigger_line_out, .trigger_line_oe);
    trig_bus_peer peer (.dut_out(trigger_line_out), .dut_oe(trigger_line_oe), .peer_val(peer_val),
        .peer_oe(peer_oe), .line(trigger_line_in));
    always #20 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 5000) begin
            n_mismatch++;
            give_verdict();
        end
    end
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // holds the request until waitrequest is sampled low, then releases it
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, input logic [3:0] be);
        @(posedge core_clk);
        read <= !wr;
        write <= wr;
        address <= a;
        writedata <= d;
        byteenable <= be;
        // only the cycle ceiling ends a wait that never sees waitrequest low
        do begin
            @(posedge core_clk);
        end while (waitrequest !== 1'h0);
        q = readdata;
        read <= 1'h0;
        write <= 1'h0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [31:0] exp);
        bus(1'h0, a, 32'h0, 4'hf);
        chk(q, exp);
    endtask
    task automatic settle;
        repeat (2) @(posedge core_clk);
        #1;
    endtask
    initial begin
        logic [3:0] c;
        logic [1:0] v;
        // a rising rst at time zero loads reset values before the first clock edge
        rst <= 1'h1;
        repeat (8) @(posedge core_clk);
        rst <= 1'h0;
        rd(4'h0, 32'h0);
        rd(4'h4, 32'h0);
        rd(4'h8, 32'h0);
        rd(4'h2, 32'h0);
        bus(1'h1, 4'h0, 32'hffffffff, 4'hf);
        rd(4'h0, 32'hf);
        bus(1'h1, 4'h8, 32'h2ca, 4'hf);
        for (int k = 0; k < 2; k++) begin
            c = k ? 4'hf : 4'h5;
            bus(1'h1, 4'h0, {28'h0, c}, 4'hf);
            for (int i = 0; i < 4; i++) begin
                v = i[1:0];
                @(posedge core_clk);
                counter2_output <= v[0];
                frequency_output <= v[0];
                counter5_output <= v[1];
                counter1_output <= v[1];
                conn_counter1_gate_input_in <= ~v[0];
                external_timer_trigger_n <= ~v[1];
                settle();
                chk({26'h0, trigger_line_oe[2:0], trigger_line_out[2:0]}, {26'h0, 3'h3, 1'h0, v});
                chk({30'h0, counter1_gate_input, timer_trigger_n},
                    {30'h0, c[1] ? v[0] : ~v[0], c[3] ? v[1] : ~v[1]});
            end
        end
        // with the drive bits clear the shared pins must not follow the counters
        bus(1'h1, 4'h0, 32'h0, 4'hf);
        @(posedge core_clk);
        counter2_output <= 1'h0;
        counter5_output <= 1'h0;
        settle();
        chk({30'h0, trigger_line_out[1:0]}, 32'h3);
        bus(1'h1, 4'h4, 32'h7f0d0b0e, 4'h7);
        rd(4'h4, 32'hd0b0e);
        bus(1'h1, 4'h0, 32'ha, 4'hf);
        peer_oe <= 7'h68;
        for (int i = 0; i < 2; i++) begin
            @(posedge core_clk);
            peer_val <= i ? 7'h28 : 7'h40;
            settle();
            chk({28'h0, external_convert_n, timer_trigger_n, counter1_gate_input, conn_convert_n_oe},
                {28'h0, i[0] ? 3'h3 : 3'h4, 1'h1});
        end
        rd(4'hc, 32'h3f7e);
        chk({30'h0, external_trigger_n, counter5_source_input}, 32'h3);
        // reset in mid-run must drop the configuration again
        @(posedge core_clk);
        rst <= 1'h1;
        repeat (2) @(posedge core_clk);
        rst <= 1'h0;
        rd(4'h0, 32'h0);
        rd(4'h4, 32'h0);
        settle();
        chk({25'h0, trigger_line_oe}, 32'h0);
        give_verdict();
    end
endmodule
bind trigger_pin_router trigger_pin_router_props chk_i (.core_clk, .rst, .address, .read, .write, .writedata,
    .byteenable, .readdata, .waitrequest, .frequency_output, .counter2_output, .counter5_output, .counter1_output,
    .counter1_gate_input, .timer_trigger_n, .conn_counter1_gate_input_in, .external_timer_trigger_n, .conn_frequency_output,
    .conn_counter2_output, .conn_counter5_output, .conn_counter1_output, .trigger_line_out, .trigger_line_oe);
